// >>> common/ncpes_regs.svh
// Offsets, command codes, field positions and timing counts for the NAND sequencer controller
`ifndef NCPES_REGS_SVH
`define NCPES_REGS_SVH

// Software register offsets (word index on the plain port)
`define NCPES_REG_CTRL 4'h0
`define NCPES_REG_ROW 4'h1
`define NCPES_REG_COL 4'h2
`define NCPES_REG_WDATA 4'h3
`define NCPES_REG_RDATA 4'h4
`define NCPES_REG_STAT 4'h5
`define NCPES_REG_DSTAT 4'h6

// Control register fields
`define NCPES_CTRL_OP_LSB 0
`define NCPES_CTRL_GO_BIT 4
`define NCPES_CTRL_WP_BIT 5

// Status register fields
`define NCPES_STAT_BUSY_BIT 0
`define NCPES_STAT_RDV_BIT 1
`define NCPES_STAT_WRDY_BIT 2
`define NCPES_STAT_RB_BIT 3

// Flash command codes
`define NCPES_CMD_READ_SETUP 8'h00
`define NCPES_CMD_READ_CONF 8'h30
`define NCPES_CMD_CACHE_NEXT 8'h31
`define NCPES_CMD_CACHE_LAST 8'h3F
`define NCPES_CMD_COL_SETUP 8'h05
`define NCPES_CMD_COL_CONF 8'hE0
`define NCPES_CMD_STATUS 8'h70
`define NCPES_CMD_LOAD 8'h80
`define NCPES_CMD_RAND_IN 8'h85
`define NCPES_CMD_PROG_CONF 8'h10
`define NCPES_CMD_CACHE_PROG 8'h15
`define NCPES_CMD_ERASE_SETUP 8'h60
`define NCPES_CMD_ERASE_CONF 8'hD0

// Flash status bit positions
`define NCPES_SR_CHIP_PF 0
`define NCPES_SR_CACHE_PF 1
`define NCPES_SR_CTRL_ACT 5
`define NCPES_SR_CACHE_RDY 6

// Strobe timing: each half of a strobe pulse, in ns, rounded up to cycles
`define NCPES_T_HALF_NS 20
`define NCPES_CLK_NS 10
`define NCPES_HALF_CYC ((`NCPES_T_HALF_NS + `NCPES_CLK_NS - 1) / `NCPES_CLK_NS)
// Busy-line settle time after a confirm code, in ns, rounded up
`define NCPES_T_WB_NS 100
`define NCPES_WB_CYC ((`NCPES_T_WB_NS + `NCPES_CLK_NS - 1) / `NCPES_CLK_NS)
`define NCPES_PAGE_BYTES 2112

`endif

// >>> common/ncpes_pkg.sv
// Types shared by the NAND cache/program/erase sequencer controller
package ncpes_pkg;

   // Operations software may launch
   typedef enum logic [3:0] {
      OP_CRD_START = 4'b0000, // 00-addr5-30
      OP_CRD_NEXT = 4'b0001, // 31
      OP_CRD_LAST = 4'b0010, // 3F
      OP_CRD_RAND = 4'b0011, // 00-row3-31
      OP_COL_CHG = 4'b0100, // 05-col2-E0
      OP_STATUS = 4'b0101, // 70 then one status byte
      OP_RESUME = 4'b0110, // 00 alone
      OP_LOAD = 4'b0111, // 80-addr5
      OP_RAND_IN = 4'b1000, // 85-col2
      OP_PROG = 4'b1001, // 10
      OP_CPROG = 4'b1010, // 15
      OP_ERASE = 4'b1011, // 60-row3-D0
      OP_DATA_IN = 4'b1100, // one byte from write data
      OP_DATA_OUT = 4'b1101 // one byte into read data
   } ncpes_op_e;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD1 = 3'b001,
      ST_ADDR = 3'b010,
      ST_CMD2 = 3'b011,
      ST_DIN = 3'b100,
      ST_DOUT = 3'b101,
      ST_WAITB = 3'b110
   } ncpes_st_e;

   // Flash pin bundle driven by the controller
   typedef struct packed {
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic read_strobe_n;
      logic wp_n;
      logic [7:0] io_out;
      logic io_oe_n;
   } ncpes_pins_s;

   // Controller state except the busy-line synchroniser and read data register
   typedef struct packed {
      ncpes_st_e st;
      ncpes_op_e op;
      logic [2:0] acnt;
      logic [2:0] alast;
      logic [2:0] afirst;
      logic [2:0] tcnt;
      logic ph;
      logic [7:0] rdata;
      logic rdv;
      logic [7:0] dstat;
      logic [7:0] wdata;
      logic wfull;
      logic [15:0] row;
      logic [11:0] col;
      logic wp;
      ncpes_pins_s pins;
   } ncpes_state_s;

endpackage

// >>> verilog/ncpes_host.sv
// Host controller that drives a NAND flash for cache read, program and erase
// Notes on behaviour
// - Cache read starts with 00, five address bytes, 30, later 31.
// - Each further sequential page is requested with 31, then wait short busy.
// - After a status poll in cache read, host sends 00 to resume.
// - Last page is requested with 3F instead of 31.
// - Random cache read: 00, row address, 31, then short busy.
// - Each further random page repeats the 00-address-31 set.
// - Program: 80, five address bytes, data bytes, then 10.
// - Host programs pages in ascending order, at most four partial programs; left to software, the controller does not check.
// - Next cache program only after cache-ready reads 1.
// - Last cache page uses 10 when only the busy line is watched.
// - During erase only status and reset accepted; busy line signals end.
// - Command latched on write-strobe rise with CLE, address with ALE.
// - Full address is two column bytes then three row bytes.
`timescale 1ns/1ps
`default_nettype none
`include "ncpes_regs.svh"

module ncpes_host (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Software port
   input wire logic [3:0] sw_addr,
   input wire logic [15:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [15:0] sw_rdata,
   // Flash pins
   output logic ce_n,
   output logic cle,
   output logic ale,
   output logic we_n,
   output logic read_strobe_n,
   output logic wp_n,
   output logic [7:0] io_out,
   output logic io_oe_n,
   input wire logic [7:0] io_in,
   input wire logic busy_n
);

   ncpes_pkg::ncpes_state_s s_reg;
   ncpes_pkg::ncpes_state_s s_next;
   logic [2:0] rb_sync_reg;
   logic rb_ready_reg;
   logic [15:0] rdata_reg;

   // Idle bus: chip selected, strobes high, pins released
   function automatic ncpes_pkg::ncpes_pins_s idle_pins(input logic wp);
      ncpes_pkg::ncpes_pins_s p;
      p = '0;
      p.we_n = 1'b1;
      p.read_strobe_n = 1'b1;
      p.wp_n = wp;
      p.io_oe_n = 1'b1;
      return p;
   endfunction

   // First command code of an operation
   function automatic logic [7:0] first_cmd(input ncpes_pkg::ncpes_op_e op);
      case (op)
         ncpes_pkg::OP_CRD_START, ncpes_pkg::OP_CRD_RAND,
         ncpes_pkg::OP_RESUME: first_cmd = `NCPES_CMD_READ_SETUP;
         ncpes_pkg::OP_CRD_NEXT: first_cmd = `NCPES_CMD_CACHE_NEXT;
         ncpes_pkg::OP_CRD_LAST: first_cmd = `NCPES_CMD_CACHE_LAST;
         ncpes_pkg::OP_COL_CHG: first_cmd = `NCPES_CMD_COL_SETUP;
         ncpes_pkg::OP_STATUS: first_cmd = `NCPES_CMD_STATUS;
         ncpes_pkg::OP_LOAD: first_cmd = `NCPES_CMD_LOAD;
         ncpes_pkg::OP_RAND_IN: first_cmd = `NCPES_CMD_RAND_IN;
         ncpes_pkg::OP_PROG: first_cmd = `NCPES_CMD_PROG_CONF;
         ncpes_pkg::OP_CPROG: first_cmd = `NCPES_CMD_CACHE_PROG;
         ncpes_pkg::OP_ERASE: first_cmd = `NCPES_CMD_ERASE_SETUP;
         default: first_cmd = `NCPES_CMD_STATUS;
      endcase
   endfunction

   // Confirm code; operations without one return zero and skip the step
   function automatic logic [7:0] conf_cmd(input ncpes_pkg::ncpes_op_e op);
      case (op)
         ncpes_pkg::OP_CRD_START: conf_cmd = `NCPES_CMD_READ_CONF;
         ncpes_pkg::OP_CRD_RAND: conf_cmd = `NCPES_CMD_CACHE_NEXT;
         ncpes_pkg::OP_COL_CHG: conf_cmd = `NCPES_CMD_COL_CONF;
         ncpes_pkg::OP_ERASE: conf_cmd = `NCPES_CMD_ERASE_CONF;
         default: conf_cmd = 8'h00;
      endcase
   endfunction

   // Address byte number: 0,1 column, 2..4 row
   function automatic logic [7:0] addr_byte(input logic [2:0] n, input logic [11:0] col,
                                            input logic [15:0] row);
      case (n)
         3'h0: addr_byte = col[7:0];
         3'h1: addr_byte = {4'h0, col[11:8]};
         3'h2: addr_byte = row[7:0];
         3'h3: addr_byte = row[15:8];
         default: addr_byte = 8'h00;
      endcase
   endfunction

   // Busy line from a pin: three flops, change once the last two agree
   always_ff @(posedge clock) begin
      if (srst) begin
         rb_sync_reg <= 3'h7;
         rb_ready_reg <= 1'b1;
      end else begin
         rb_sync_reg <= {rb_sync_reg[1:0], busy_n};
         if (rb_sync_reg[2] == rb_sync_reg[1]) begin
            rb_ready_reg <= rb_sync_reg[2];
         end
      end
   end

   // Sequencer next state
   always_comb begin
      logic [2:0] af;
      logic [2:0] al;
      logic [7:0] cc;
      logic is_pe;
      af = 3'h0;
      al = 3'h0;
      cc = 8'h00;
      is_pe = 1'b0;
      s_next = s_reg;
      // Software writes
      if (sw_wr && sw_addr == `NCPES_REG_ROW) begin
         s_next.row = sw_wdata; // page order and partial counts stay with software
      end else if (sw_wr && sw_addr == `NCPES_REG_COL) begin
         s_next.col = sw_wdata[11:0];
      end else if (sw_wr && sw_addr == `NCPES_REG_WDATA) begin
         s_next.wdata = sw_wdata[7:0];
         s_next.wfull = 1'b1;
      end
      if (sw_rd && sw_addr == `NCPES_REG_RDATA) begin
         s_next.rdv = 1'b0;
      end
      case (s_reg.st)
         ncpes_pkg::ST_IDLE: begin
            s_next.pins = idle_pins(s_reg.wp);
            if (sw_wr && sw_addr == `NCPES_REG_CTRL) begin
               s_next.wp = sw_wdata[`NCPES_CTRL_WP_BIT];
               s_next.pins.wp_n = sw_wdata[`NCPES_CTRL_WP_BIT];
               if (sw_wdata[`NCPES_CTRL_GO_BIT]) begin
                  s_next.op = ncpes_pkg::ncpes_op_e'(sw_wdata[`NCPES_CTRL_OP_LSB +: 4]);
                  s_next.tcnt = 3'h0;
                  s_next.ph = 1'b0;
                  // Pick address bytes to send for this operation
                  case (ncpes_pkg::ncpes_op_e'(sw_wdata[`NCPES_CTRL_OP_LSB +: 4]))
                     ncpes_pkg::OP_CRD_START, ncpes_pkg::OP_LOAD: begin
                        af = 3'h0;
                        al = 3'h4;
                     end
                     ncpes_pkg::OP_CRD_RAND, ncpes_pkg::OP_ERASE: begin
                        af = 3'h2;
                        al = 3'h4;
                     end
                     ncpes_pkg::OP_COL_CHG, ncpes_pkg::OP_RAND_IN: begin
                        af = 3'h0;
                        al = 3'h1;
                     end
                     default: begin
                        af = 3'h7;
                        al = 3'h7;
                     end
                  endcase
                  s_next.afirst = af;
                  s_next.alast = al;
                  s_next.acnt = af;
                  if (ncpes_pkg::ncpes_op_e'(sw_wdata[`NCPES_CTRL_OP_LSB +: 4]) ==
                      ncpes_pkg::OP_DATA_IN) begin
                     s_next.st = ncpes_pkg::ST_DIN;
                  end else if (ncpes_pkg::ncpes_op_e'(sw_wdata[`NCPES_CTRL_OP_LSB +: 4]) ==
                               ncpes_pkg::OP_DATA_OUT) begin
                     s_next.st = ncpes_pkg::ST_DOUT;
                  end else begin
                     s_next.st = ncpes_pkg::ST_CMD1;
                  end
               end
            end
         end
         ncpes_pkg::ST_CMD1, ncpes_pkg::ST_CMD2, ncpes_pkg::ST_ADDR: begin
            // One latch cycle: strobe low half, then high half; data latched on the rise
            if (s_reg.st == ncpes_pkg::ST_ADDR) begin
               cc = addr_byte(s_reg.acnt, s_reg.col, s_reg.row);
            end else if (s_reg.st == ncpes_pkg::ST_CMD1) begin
               cc = first_cmd(s_reg.op);
            end else begin
               cc = conf_cmd(s_reg.op);
            end
            s_next.pins.cle = (s_reg.st != ncpes_pkg::ST_ADDR);
            s_next.pins.ale = (s_reg.st == ncpes_pkg::ST_ADDR);
            s_next.pins.io_out = cc;
            s_next.pins.io_oe_n = 1'b0;
            s_next.pins.we_n = s_reg.ph;
            s_next.tcnt = s_reg.tcnt + 3'h1;
            if (s_reg.tcnt == 3'(`NCPES_HALF_CYC - 1)) begin
               s_next.tcnt = 3'h0;
               s_next.ph = ~s_reg.ph;
               if (s_reg.ph) begin
                  s_next.pins = idle_pins(s_reg.wp);
                  is_pe = (s_reg.op == ncpes_pkg::OP_ERASE) ||
                          (s_reg.op == ncpes_pkg::OP_PROG) ||
                          (s_reg.op == ncpes_pkg::OP_CPROG);
                  if (s_reg.st == ncpes_pkg::ST_CMD1 && s_reg.afirst != 3'h7) begin
                     s_next.st = ncpes_pkg::ST_ADDR;
                  end else if (s_reg.st == ncpes_pkg::ST_ADDR && s_reg.acnt != s_reg.alast) begin
                     s_next.acnt = s_reg.acnt + 3'h1;
                  end else if (s_reg.st != ncpes_pkg::ST_CMD2 &&
                               conf_cmd(s_reg.op) != 8'h00) begin
                     s_next.st = ncpes_pkg::ST_CMD2;
                  end else if (s_reg.op == ncpes_pkg::OP_STATUS) begin
                     s_next.st = ncpes_pkg::ST_DOUT;
                  end else if (s_reg.op == ncpes_pkg::OP_CRD_START ||
                               s_reg.op == ncpes_pkg::OP_CRD_RAND ||
                               s_reg.op == ncpes_pkg::OP_CRD_NEXT ||
                               s_reg.op == ncpes_pkg::OP_CRD_LAST || is_pe) begin
                     // Busy line takes a while to fall after a confirm code
                     s_next.st = ncpes_pkg::ST_WAITB;
                     s_next.acnt = 3'h0;
                  end else begin
                     s_next.st = ncpes_pkg::ST_IDLE;
                  end
               end
            end
         end
         ncpes_pkg::ST_DIN: begin
            // Stall until software has supplied a byte
            if (s_reg.wfull) begin
               s_next.pins.io_out = s_reg.wdata;
               s_next.pins.io_oe_n = 1'b0;
               s_next.pins.we_n = s_reg.ph;
               s_next.tcnt = s_reg.tcnt + 3'h1;
               if (s_reg.tcnt == 3'(`NCPES_HALF_CYC - 1)) begin
                  s_next.tcnt = 3'h0;
                  s_next.ph = ~s_reg.ph;
                  if (s_reg.ph) begin
                     s_next.pins = idle_pins(s_reg.wp);
                     s_next.wfull = sw_wr && sw_addr == `NCPES_REG_WDATA; // New byte wins
                     s_next.st = ncpes_pkg::ST_IDLE;
                  end
               end
            end
         end
         ncpes_pkg::ST_DOUT: begin
            // Sample just before the read strobe rises; its fall advanced the column
            s_next.pins.read_strobe_n = s_reg.ph;
            s_next.tcnt = s_reg.tcnt + 3'h1;
            if (s_reg.tcnt == 3'(`NCPES_HALF_CYC - 1)) begin
               s_next.tcnt = 3'h0;
               s_next.ph = ~s_reg.ph;
               if (!s_reg.ph) begin
                  if (s_reg.op == ncpes_pkg::OP_STATUS) begin
                     s_next.dstat = io_in;
                  end else begin
                     s_next.rdata = io_in;
                     s_next.rdv = 1'b1;
                  end
               end else begin
                  s_next.pins = idle_pins(s_reg.wp);
                  s_next.st = ncpes_pkg::ST_IDLE;
               end
            end
         end
         ncpes_pkg::ST_WAITB: begin
            // Count the busy-fall window to at most 7, not the full NCPES_WB_CYC, then wait for ready; chip select stays low
            if (s_reg.acnt != 3'(`NCPES_WB_CYC > 7 ? 7 : `NCPES_WB_CYC)) begin
               s_next.acnt = s_reg.acnt + 3'h1;
            end else if (rb_ready_reg) begin
               s_next.st = ncpes_pkg::ST_IDLE;
            end
         end
         default: s_next.st = ncpes_pkg::ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clock) begin
      if (srst) begin
         s_reg <= '0;
         s_reg.pins.we_n <= 1'b1;
         s_reg.pins.read_strobe_n <= 1'b1;
         s_reg.pins.io_oe_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Read port: data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clock) begin
      if (srst) begin
         rdata_reg <= 16'h0000;
      end else if (sw_rd) begin
         if (sw_addr == `NCPES_REG_CTRL) begin
            rdata_reg <= {10'h000, s_reg.wp, 1'b0, s_reg.op};
         end else if (sw_addr == `NCPES_REG_ROW) begin
            rdata_reg <= s_reg.row;
         end else if (sw_addr == `NCPES_REG_COL) begin
            rdata_reg <= {4'h0, s_reg.col};
         end else if (sw_addr == `NCPES_REG_RDATA) begin
            rdata_reg <= {8'h00, s_reg.rdata};
         end else if (sw_addr == `NCPES_REG_STAT) begin
            rdata_reg <= {12'h000, rb_ready_reg, ~s_reg.wfull, s_reg.rdv,
                          s_reg.st != ncpes_pkg::ST_IDLE};
         end else if (sw_addr == `NCPES_REG_DSTAT) begin
            rdata_reg <= {8'h00, s_reg.dstat};
         end else begin
            rdata_reg <= 16'h0000;
         end
      end else begin
         rdata_reg <= 16'h0000;
      end
   end

   assign sw_rdata = rdata_reg;
   assign ce_n = s_reg.pins.ce_n;
   assign cle = s_reg.pins.cle;
   assign ale = s_reg.pins.ale;
   assign we_n = s_reg.pins.we_n;
   assign read_strobe_n = s_reg.pins.read_strobe_n;
   assign wp_n = s_reg.pins.wp_n;
   assign io_out = s_reg.pins.io_out;
   assign io_oe_n = s_reg.pins.io_oe_n;
   // Command and address strobes never overlap
   a_latch_excl: assert property (@(posedge clock) disable iff (srst)
      !(cle && ale)) else $error("cle and ale both high");
   // Write strobe low only with the bus driven
   a_we_drives: assert property (@(posedge clock) disable iff (srst)
      !we_n |-> !io_oe_n) else $error("write strobe without bus drive");
   sequence s_conf_sent;
      s_reg.st == ncpes_pkg::ST_CMD2 && s_reg.ph && s_next.st == ncpes_pkg::ST_WAITB;
   endsequence
   // After a confirm, the wait state lasts at least eight cycles
   a_wait_ready: assert property (@(posedge clock) disable iff (srst)
      s_conf_sent |=> (s_reg.st == ncpes_pkg::ST_WAITB)[*8]) else $error("wait cut short");
   // Leaving the wait requires the busy line to be ready
   a_ready_exit: assert property (@(posedge clock) disable iff (srst)
      s_reg.st == ncpes_pkg::ST_WAITB && s_next.st == ncpes_pkg::ST_IDLE |-> rb_ready_reg)
      else $error("left wait while busy");
   // Chip select held low while the device is busy
   a_ce_held: assert property (@(posedge clock) disable iff (srst)
      s_reg.st == ncpes_pkg::ST_WAITB |-> !ce_n) else $error("chip select toggled");
   // Read strobe and write strobe never low together
   a_strobe_excl: assert property (@(posedge clock) disable iff (srst)
      !(!we_n && !read_strobe_n)) else $error("both strobes low");
   // Read strobe low only with the bus released
   a_re_released: assert property (@(posedge clock) disable iff (srst)
      !read_strobe_n |-> io_oe_n) else $error("read while driving");
   // Address latch only during address phase
   a_ale_phase: assert property (@(posedge clock) disable iff (srst)
      ale |-> $past(s_reg.st) == ncpes_pkg::ST_ADDR) else $error("ale out of phase");
endmodule

`default_nettype wire

// >>> verification/ncpes_flash_model.sv
// Behavioural NAND flash answering the controller pins
`timescale 1ns/1ps
`default_nettype none

module ncpes_flash_model (
   // Pins from the controller
   input wire logic cle,
   input wire logic ale,
   input wire logic we_n,
   input wire logic read_strobe_n,
   input wire logic wp_n,
   input wire logic [7:0] io_out,
   // Bench control
   input wire logic fail_req,
   // Pins to the controller
   output logic [7:0] dq,
   output logic busy_n
);
   logic [7:0] ab [0:4];
   logic [15:0] row = 16'h0000;
   logic [15:0] cur = 16'h0000;
   logic [15:0] nxt = 16'h0000;
   logic [11:0] col = 12'h000;
   logic chpf = 1'b0;
   logic cpf = 1'b0;
   logic stat_mode = 1'b0;
   int n = 0;
   int busy_cnt = 0;

   initial begin
      busy_n = 1'b1;
      dq = 8'h00;
   end

   // Latch on write strobe rise: address, command or data
   always @(posedge we_n) begin
      if (ale) begin
         ab[n % 5] = io_out;
         n++;
         // Column takes effect after two bytes so data input can follow at once
         if (n == 2) col = {ab[1][3:0], ab[0]};
         if (n == 5) row = {ab[3], ab[2]};
      end else if (cle) begin
         stat_mode = (io_out == 8'h70);
         if (io_out == 8'h30) begin
            nxt = row;
            busy_n = 1'b0;
            busy_n <= #250 1'b1;
         end
         if (io_out == 8'h31 || io_out == 8'h3F) begin
            cur = (n == 3) ? {ab[1], ab[0]} : nxt;
            col = 12'h000;
            nxt = cur + 16'h0001;
            busy_n = 1'b0;
            busy_n <= #250 1'b1;
         end
         if (wp_n && (io_out == 8'h10 || io_out == 8'h15 || io_out == 8'hD0)) begin
            if (io_out == 8'h15) cpf = chpf;
            chpf = fail_req;
            busy_cnt++;
            busy_n = 1'b0;
            busy_n <= #400 1'b1;
         end
         n = 0;
      end else begin
         col++;
      end
   end

   // Data out on read strobe fall, column counter advances outside status mode
   always @(negedge read_strobe_n) begin
      dq = stat_mode ? {wp_n, busy_n, busy_n, 3'b000, cpf, chpf} : cur[7:0] ^ col[7:0];
      if (!stat_mode) col++;
   end

   // Released bus shows a changed value, never the last byte
   always @(posedge read_strobe_n) dq = ~dq;
endmodule

`default_nettype wire

// >>> verification/ncpes_host_tb.sv
// Testbench for the NAND host controller
`timescale 1ns/1ps
`default_nettype none

module ncpes_host_tb;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [3:0] sw_addr = 4'h0;
   logic [15:0] sw_wdata = 16'h0000;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic fail_req = 1'b0;
   logic wp = 1'b1;
   wire logic [15:0] sw_rdata;
   wire logic ce_n, cle, ale, we_n, read_strobe_n, wp_n, io_oe_n, busy_n;
   wire logic [7:0] io_out, dq, io_in;
   logic [15:0] v;
   int miscompares = 0;
   int n_tests = 0;
   int cycles = 0;
   int b0;

   always #5 clock = ~clock;
   // Shared data wire: controller wins while it drives
   assign io_in = io_oe_n ? dq : io_out;

   ncpes_host dut (.clock(clock), .srst(srst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .ce_n(ce_n), .cle(cle), .ale(ale),
      .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out),
      .io_oe_n(io_oe_n), .io_in(io_in), .busy_n(busy_n));
   ncpes_flash_model flash (.cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n),
      .wp_n(wp_n), .io_out(io_out), .fail_req(fail_req), .dq(dq), .busy_n(busy_n));

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Hang guard, well above the expected run length
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         report_and_stop;
      end
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One-cycle write, a quiet cycle after so strobes never merge
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clock);
      sw_wr <= 1'b0;
      @(posedge clock);
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clock);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
      @(posedge clock);
   endtask

   // Launch an operation and poll until idle
   task automatic op(input logic [3:0] code);
      logic [15:0] s;
      int i;
      wr(4'h0, {10'h000, wp, 1'b1, code});
      for (i = 0; i < 1000; i++) begin
         rd(4'h5, s);
         if (s[0] === 1'b0) break;
      end
      if (i == 1000) chk("op done", 16'h0000, s);
   endtask

   task automatic get_byte(input string nm, input logic [7:0] e);
      op(4'hD);
      rd(4'h4, v);
      chk(nm, {8'h00, e}, {8'h00, v[7:0]});
   endtask

   task automatic status(input logic [7:0] e);
      op(4'h5);
      rd(4'h6, v);
      chk("flash status", {8'h00, e}, {8'h00, v[7:0]});
   endtask

   initial begin
      repeat (10) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      chk("wp_n at reset", 16'h0000, {15'h0000, wp_n});
      chk("ce_n at reset", 16'h0000, {15'h0000, ce_n});
      // Sequential cache read crossing a block edge
      wr(4'h1, 16'h003F);
      wr(4'h2, 16'h0004);
      op(4'h0);
      op(4'h1);
      get_byte("page start", 8'h3F);
      get_byte("page next col", 8'h3E);
      wr(4'h2, 16'h0005);
      op(4'h4);
      get_byte("col change", 8'h3A);
      op(4'h1);
      get_byte("next block", 8'h40);
      status(8'hE0);
      op(4'h6);
      get_byte("resume", 8'h41);
      op(4'h2);
      get_byte("last page", 8'h41);
      wr(4'h1, 16'h0123);
      op(4'h3);
      get_byte("random page", 8'h23);
      $display("cache read tests done");
      // Program with random data input, failing result
      wr(4'h1, 16'h0010);
      wr(4'h2, 16'h0000);
      op(4'h7);
      wr(4'h3, 16'h00AA);
      op(4'hC);
      wr(4'h2, 16'h0100);
      op(4'h8);
      wr(4'h3, 16'h0055);
      op(4'hC);
      chk("load column", 16'h0101, {4'h0, flash.col});
      fail_req = 1'b1;
      op(4'h9);
      status(8'hE1);
      // Cache program reports the earlier failure separately
      fail_req = 1'b0;
      op(4'h7);
      op(4'hA);
      status(8'hE2);
      $display("program tests done");
      b0 = flash.busy_cnt;
      op(4'hB);
      chk("erase busy", 16'h0001, 16'(flash.busy_cnt - b0));
      wp = 1'b0;
      op(4'hB);
      chk("protected erase", 16'h0001, 16'(flash.busy_cnt - b0));
      $display("erase tests done");
      report_and_stop;
   end
endmodule

`default_nettype wire
